/* include/mcs_defs.vh */
// Purpose: Constants for the measurement command sequencer.
// Assumes: One clock, ref_clk at 25 MHz, synchronous active-low reset.
// Notes: Codes below are the command port encoding of the sequencer.
//
// Function
// - Self-test sums program ROM, queues 0 on pass, 1 on fail.
// - Queued result leaves only when the host has addressed us to talk.
// - A sequential command completes before the next one is taken.
// - Wait holds later commands until all overlapped work is done.
// - Only initiate, continuous-on initiate and bus trigger overlap.
// - Initiate stays pending until the trigger model is idle again.
// - Bus trigger stays pending until the trigger model settles.
// - Configure changes function only; the input channel is kept.
// - Configure loads defaults, continuous off, immediate, counts one.
// - Configure idles, disables math and stepping, aborts storage.
// - Fetch returns the latest reading, repeating it until a new one.
// - Read does abort, initiate, fetch in order, storing readings.
// - Abort idles, or restarts the trigger model if continuous is on.
// - Initiate leaves idle; with continuous on it errors instead.
// - Read with sample count above one and a full buffer errors -225.
// - Measure does abort, configure, then read, in order.
// - A bus trigger acts only when the control source is bus.
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH

// Command codes on cmd_code.
`define MCS_CMD_TST 4'h0
`define MCS_CMD_WAI 4'h1
`define MCS_CMD_INIT 4'h2
`define MCS_CMD_CONT_ON 4'h3
`define MCS_CMD_CONT_OFF 4'h4
`define MCS_CMD_TRG 4'h5
`define MCS_CMD_CONF 4'h6
`define MCS_CMD_FETCH 4'h7
`define MCS_CMD_READ 4'h8
`define MCS_CMD_MEAS 4'h9
`define MCS_CMD_ABORT 4'hA
`define MCS_CMD_SRC 4'hB

// Functions and trigger control sources on cmd_arg.
`define MCS_FUNC_VOLT 2'h0
`define MCS_FUNC_TEMP 2'h1
`define MCS_SRC_IMM 2'h0
`define MCS_SRC_BUS 2'h1

// Sequencer states.
`define MCS_ST_IDLE 3'h0
`define MCS_ST_TST 3'h1
`define MCS_ST_WAIT 3'h2
`define MCS_ST_RD_WAIT 3'h3
`define MCS_ST_OQ 3'h4
`define MCS_ST_RD_INIT 3'h5
`define MCS_ST_RD_CHK 3'h6

// Self-test: ROM size and the sum a good image gives.
`define MCS_ROM_LAST 9'h100
`define MCS_ROM_SUM_OK 8'h00
`define MCS_TST_PASS 24'h000000
`define MCS_TST_FAIL 24'h000001

// Error codes, two's complement.
`define MCS_ERR_MEMORY 16'hFF1F
`define MCS_ERR_INIT_IGN 16'hFF2B

// Reset values.
`define MCS_RST_FUNC 2'h0
`define MCS_RST_SRC 2'h0

`endif

/* src/mcs_sequencer.v */
// Purpose: Executes remote-interface commands for the measurement core.
// Assumes: Command port and trigger model run on ref_clk; talk_addressed
//   comes from the link and is synchronised here.
// Notes: Queries leave through a one-entry output queue.
`timescale 1ns/10ps
`include "mcs_defs.vh"

module mcs_sequencer (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_n,
  // Command port.
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [1:0] cmd_arg,
  output reg cmd_ready_ff,
  // Link side.
  input wire talk_addressed,
  output reg tx_strobe_ff,
  output reg [23:0] tx_data_ff,
  output reg err_strobe_ff,
  output reg [15:0] err_code_ff,
  // Program ROM for the self-test.
  output reg [7:0] rom_addr_ff,
  input wire [7:0] rom_data,
  // Trigger model.
  input wire tm_idle,
  input wire tm_settled,
  output reg tm_start_ff,
  output reg tm_restart_ff,
  output reg tm_abort_ff,
  output reg tm_bus_trig_ff,
  // Readings and buffer.
  input wire rd_new,
  input wire [23:0] rd_value,
  input wire [15:0] sample_count,
  input wire buf_has_data,
  output reg buf_store_en_ff,
  output reg buf_abort_ff,
  // Configuration.
  output reg [1:0] func_ff,
  output reg [1:0] trig_src_ff,
  output reg cont_init_ff,
  output reg cfg_defaults_ff
);

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [8:0] rom_cnt_ff;
  reg [8:0] nxt_rom_cnt;
  reg [7:0] sum_ff;
  reg [7:0] nxt_sum;
  reg pend_init_ff;
  reg nxt_pend_init;
  reg pend_trg_ff;
  reg nxt_pend_trg;
  reg oq_valid_ff;
  reg nxt_oq_valid;
  reg [23:0] oq_data_ff;
  reg [23:0] nxt_oq_data;
  reg [23:0] latest_ff;
  reg talk_q1_ff;
  reg talk_q2_ff;
  reg talk_q3_ff;
  reg talk_ff;
  reg nxt_tx_strobe;
  reg [23:0] nxt_tx_data;
  reg nxt_err_strobe;
  reg [15:0] nxt_err_code;
  reg nxt_tm_start;
  reg nxt_tm_restart;
  reg nxt_tm_abort;
  reg nxt_tm_bus_trig;
  reg nxt_buf_store_en;
  reg nxt_buf_abort;
  reg [1:0] nxt_func;
  reg [1:0] nxt_trig_src;
  reg nxt_cont_init;
  reg nxt_cfg_defaults;
  reg do_abort;
  wire take;
  wire [23:0] fresh;

  assign take = cmd_valid & cmd_ready_ff;
  // A reading arriving this cycle is newer than the stored one.
  assign fresh = rd_new ? rd_value : latest_ff;

  //////////////////////////////////////////////////////////////////////////
  // Talk-address synchroniser; a change counts when stages two and three
  // agree.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      talk_q1_ff <= 1'b0;
      talk_q2_ff <= 1'b0;
      talk_q3_ff <= 1'b0;
      talk_ff <= 1'b0;
    end
    else
    begin
      talk_q1_ff <= talk_addressed;
      talk_q2_ff <= talk_q1_ff;
      talk_q3_ff <= talk_q2_ff;
      if (talk_q2_ff == talk_q3_ff)
        talk_ff <= talk_q3_ff;
    end
  end

  // Latest post-processed reading, held until a newer one comes.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      latest_ff <= 24'h000000;
    else if (rd_new)
      latest_ff <= rd_value;
  end

  //////////////////////////////////////////////////////////////////////////
  // Command sequencing and next-state logic.
  always @*
  begin
    nxt_state = state_ff;
    nxt_rom_cnt = rom_cnt_ff;
    nxt_sum = sum_ff;
    nxt_pend_init = pend_init_ff;
    nxt_pend_trg = pend_trg_ff;
    nxt_oq_valid = oq_valid_ff;
    nxt_oq_data = oq_data_ff;
    nxt_tx_strobe = 1'b0;
    nxt_tx_data = tx_data_ff;
    nxt_err_strobe = 1'b0;
    nxt_err_code = err_code_ff;
    nxt_tm_start = 1'b0;
    nxt_tm_restart = 1'b0;
    nxt_tm_abort = 1'b0;
    nxt_tm_bus_trig = 1'b0;
    nxt_buf_store_en = buf_store_en_ff;
    nxt_buf_abort = 1'b0;
    nxt_func = func_ff;
    nxt_trig_src = trig_src_ff;
    nxt_cont_init = cont_init_ff;
    nxt_cfg_defaults = 1'b0;
    do_abort = 1'b0;
    // Overlapped work retires on the trigger model's own signals; the
    // cycle that issues a start ignores a stale idle.
    if (tm_idle && !tm_start_ff)
      nxt_pend_init = 1'b0;
    if (tm_settled)
      nxt_pend_trg = 1'b0;
    // Output queue drains only while addressed to talk.
    if (oq_valid_ff && talk_ff && !tx_strobe_ff)
    begin
      nxt_tx_strobe = 1'b1;
      nxt_tx_data = oq_data_ff;
      nxt_oq_valid = 1'b0;
    end
    case (state_ff)
      `MCS_ST_IDLE:
      begin
        if (take)
        begin
          case (cmd_code)
            `MCS_CMD_TST:
            begin
              nxt_rom_cnt = 9'h000;
              nxt_sum = 8'h00;
              nxt_state = `MCS_ST_TST;
            end
            `MCS_CMD_WAI:
              nxt_state = `MCS_ST_WAIT;
            `MCS_CMD_INIT:
            begin
              if (cont_init_ff)
              begin
                nxt_err_strobe = 1'b1;
                nxt_err_code = `MCS_ERR_INIT_IGN;
              end
              else
              begin
                nxt_tm_start = 1'b1;
                nxt_pend_init = 1'b1;
              end
            end
            `MCS_CMD_CONT_ON:
            begin
              nxt_cont_init = 1'b1;
              nxt_tm_start = 1'b1;
              nxt_pend_init = 1'b1;
            end
            `MCS_CMD_CONT_OFF:
              nxt_cont_init = 1'b0;
            `MCS_CMD_TRG:
            begin
              if (trig_src_ff == `MCS_SRC_BUS)
              begin
                nxt_tm_bus_trig = 1'b1;
                nxt_pend_trg = 1'b1;
              end
            end
            `MCS_CMD_CONF:
            begin
              nxt_func = cmd_arg;
              nxt_cont_init = 1'b0;
              nxt_trig_src = `MCS_SRC_IMM;
              nxt_cfg_defaults = 1'b1;
              nxt_tm_abort = 1'b1;
              nxt_buf_store_en = 1'b0;
              nxt_buf_abort = 1'b1;
            end
            `MCS_CMD_FETCH:
            begin
              nxt_oq_valid = 1'b1;
              nxt_oq_data = fresh;
              nxt_state = `MCS_ST_OQ;
            end
            `MCS_CMD_READ:
              nxt_state = `MCS_ST_RD_CHK;
            `MCS_CMD_MEAS:
            begin
              do_abort = 1'b1;
              nxt_func = cmd_arg;
              nxt_cont_init = 1'b0;
              nxt_trig_src = `MCS_SRC_IMM;
              nxt_cfg_defaults = 1'b1;
              nxt_buf_store_en = 1'b0;
              nxt_buf_abort = 1'b1;
              nxt_state = `MCS_ST_RD_CHK;
            end
            `MCS_CMD_ABORT:
              do_abort = 1'b1;
            `MCS_CMD_SRC:
              nxt_trig_src = cmd_arg;
            default:
              nxt_state = `MCS_ST_IDLE;
          endcase
        end
      end
      `MCS_ST_TST:
      begin
        // ROM data lags the address by one cycle.
        nxt_rom_cnt = rom_cnt_ff + 9'h001;
        if (rom_cnt_ff != 9'h000)
          nxt_sum = sum_ff + rom_data;
        if (rom_cnt_ff == `MCS_ROM_LAST)
        begin
          nxt_oq_valid = 1'b1;
          nxt_oq_data = (nxt_sum == `MCS_ROM_SUM_OK) ?
            `MCS_TST_PASS : `MCS_TST_FAIL;
          nxt_state = `MCS_ST_OQ;
        end
      end
      `MCS_ST_WAIT:
      begin
        if (!pend_init_ff && !pend_trg_ff)
          nxt_state = `MCS_ST_IDLE;
      end
      `MCS_ST_RD_CHK:
      begin
        if (sample_count > 16'h0001 && buf_has_data)
        begin
          nxt_err_strobe = 1'b1;
          nxt_err_code = `MCS_ERR_MEMORY;
          nxt_state = `MCS_ST_IDLE;
        end
        else
        begin
          do_abort = 1'b1;
          nxt_state = `MCS_ST_RD_INIT;
        end
      end
      `MCS_ST_RD_INIT:
      begin
        if (cont_init_ff)
        begin
          nxt_err_strobe = 1'b1;
          nxt_err_code = `MCS_ERR_INIT_IGN;
          nxt_oq_valid = 1'b1;
          nxt_oq_data = fresh;
          nxt_state = `MCS_ST_OQ;
        end
        else
        begin
          nxt_tm_start = 1'b1;
          nxt_buf_store_en = 1'b1;
          nxt_state = `MCS_ST_RD_WAIT;
        end
      end
      `MCS_ST_RD_WAIT:
      begin
        if (tm_idle && !tm_start_ff)
        begin
          nxt_buf_store_en = 1'b0;
          nxt_oq_valid = 1'b1;
          nxt_oq_data = fresh;
          nxt_state = `MCS_ST_OQ;
        end
      end
      `MCS_ST_OQ:
      begin
        if (!oq_valid_ff)
          nxt_state = `MCS_ST_IDLE;
      end
      default:
        nxt_state = `MCS_ST_IDLE;
    endcase
    // Abort idles the model, or restarts it under continuous initiation.
    if (do_abort)
    begin
      if (cont_init_ff && nxt_cont_init)
        nxt_tm_restart = 1'b1;
      else
        nxt_tm_abort = 1'b1;
    end
    // New overlapped work wins over a retire in the same cycle.
    if (take && state_ff == `MCS_ST_IDLE && cmd_code == `MCS_CMD_TRG &&
        trig_src_ff == `MCS_SRC_BUS)
      nxt_pend_trg = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // State registers.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_ff <= `MCS_ST_IDLE;
      cmd_ready_ff <= 1'b0;
      rom_cnt_ff <= 9'h000;
      rom_addr_ff <= 8'h00;
      sum_ff <= 8'h00;
      pend_init_ff <= 1'b0;
      pend_trg_ff <= 1'b0;
      oq_valid_ff <= 1'b0;
      oq_data_ff <= 24'h000000;
      tx_strobe_ff <= 1'b0;
      tx_data_ff <= 24'h000000;
      err_strobe_ff <= 1'b0;
      err_code_ff <= 16'h0000;
      tm_start_ff <= 1'b0;
      tm_restart_ff <= 1'b0;
      tm_abort_ff <= 1'b0;
      tm_bus_trig_ff <= 1'b0;
      buf_store_en_ff <= 1'b0;
      buf_abort_ff <= 1'b0;
      func_ff <= `MCS_RST_FUNC;
      trig_src_ff <= `MCS_RST_SRC;
      cont_init_ff <= 1'b0;
      cfg_defaults_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ready_ff <= (nxt_state == `MCS_ST_IDLE);
      rom_cnt_ff <= nxt_rom_cnt;
      rom_addr_ff <= nxt_rom_cnt[7:0];
      sum_ff <= nxt_sum;
      pend_init_ff <= nxt_pend_init;
      pend_trg_ff <= nxt_pend_trg;
      oq_valid_ff <= nxt_oq_valid;
      oq_data_ff <= nxt_oq_data;
      tx_strobe_ff <= nxt_tx_strobe;
      tx_data_ff <= nxt_tx_data;
      err_strobe_ff <= nxt_err_strobe;
      err_code_ff <= nxt_err_code;
      tm_start_ff <= nxt_tm_start;
      tm_restart_ff <= nxt_tm_restart;
      tm_abort_ff <= nxt_tm_abort;
      tm_bus_trig_ff <= nxt_tm_bus_trig;
      buf_store_en_ff <= nxt_buf_store_en;
      buf_abort_ff <= nxt_buf_abort;
      func_ff <= nxt_func;
      trig_src_ff <= nxt_trig_src;
      cont_init_ff <= nxt_cont_init;
      cfg_defaults_ff <= nxt_cfg_defaults;
    end
  end

endmodule // mcs_sequencer

/* sim/mcs_seq_checker.sv */
// Purpose: Port assertions for the command sequencer.
// Assumes: One clock ref_clk, synchronous active-low rst_n.
// Notes: Bound to every mcs_sequencer instance.
`timescale 1ns/10ps
`include "mcs_defs.vh"
module mcs_seq_checker (
  // Clock, reset and command port.
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_ready_ff,
  // Link and errors.
  input wire logic talk_addressed,
  input wire logic tx_strobe_ff,
  input wire logic err_strobe_ff,
  input wire logic [15:0] err_code_ff,
  // Trigger model, buffer and setup.
  input wire logic tm_start_ff,
  input wire logic tm_abort_ff,
  input wire logic tm_bus_trig_ff,
  input wire logic [15:0] sample_count,
  input wire logic buf_has_data,
  input wire logic [1:0] trig_src_ff,
  input wire logic cont_init_ff,
  input wire logic cfg_defaults_ff
);
  logic take;
  logic full;
  //////////////////////////////////////////////////////////////////////////
  // A taken command, and a read that the buffer state must refuse.
  assign take = cmd_valid && cmd_ready_ff;
  assign full = (sample_count > 16'h0001) && buf_has_data;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  AST_TX_TALK: assert property (tx_strobe_ff
    |-> $past(talk_addressed, 3))
    else $error("Response sent while not addressed to talk.");
  AST_SEQ_HOLD: assert property (take && cmd_code >= `MCS_CMD_FETCH
    && cmd_code <= `MCS_CMD_MEAS |=> !cmd_ready_ff)
    else $error("Sequential command did not hold the port.");
  AST_TST_LEN: assert property (take && cmd_code == `MCS_CMD_TST
    |=> !cmd_ready_ff [*8]) else $error("Self-test ended too soon.");
  AST_CONF_DEF: assert property (take && cmd_code == `MCS_CMD_CONF
    |-> ##[1:2] cfg_defaults_ff ##[0:1]
    (!cont_init_ff && trig_src_ff == `MCS_SRC_IMM))
    else $error("Configure did not load defaults.");
  AST_BUS_SRC: assert property (tm_bus_trig_ff
    |-> trig_src_ff == `MCS_SRC_BUS)
    else $error("Bus trigger acted with another source.");
  AST_READ_SEQ: assert property (take && cmd_code == `MCS_CMD_READ
    && !full && !cont_init_ff |-> ##2 tm_abort_ff ##1 tm_start_ff)
    else $error("Read did not abort then initiate.");
  AST_READ_ERR: assert property (take && cmd_code == `MCS_CMD_READ
    && full && !cont_init_ff
    |-> ##2 (err_strobe_ff && err_code_ff == `MCS_ERR_MEMORY))
    else $error("Read on a full buffer was not refused.");
  AST_INIT_IGN: assert property (take && cmd_code == `MCS_CMD_INIT
    && cont_init_ff
    |-> ##[1:2] (err_strobe_ff && err_code_ff == `MCS_ERR_INIT_IGN))
    else $error("Initiate in continuous mode gave no error.");
endmodule // mcs_seq_checker

bind mcs_sequencer mcs_seq_checker i_chk (.ref_clk, .rst_n, .cmd_valid,
  .cmd_code, .cmd_ready_ff, .talk_addressed, .tx_strobe_ff, .err_strobe_ff,
  .err_code_ff, .tm_start_ff, .tm_abort_ff, .tm_bus_trig_ff, .sample_count,
  .buf_has_data, .trig_src_ff, .cont_init_ff, .cfg_defaults_ff);

/* sim/mcs_core_model.sv */
// Purpose: Measurement core behind the sequencer: ROM, trigger model, data.
// Assumes: Registered ROM, one cycle from address to data.
// Notes: rd_value is scrambled whenever rd_new is low.
`timescale 1ns/10ps
module mcs_core_model #(
  parameter logic [7:0] MEAS_CYC = 8'h14,
  parameter logic [3:0] TRIG_CYC = 4'hC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Program ROM.
  input wire logic [7:0] rom_addr,
  input wire logic rom_bad,
  output logic [7:0] rom_data,
  // Trigger model.
  input wire logic tm_start,
  input wire logic tm_restart,
  input wire logic tm_abort,
  input wire logic tm_bus_trig,
  output logic tm_idle,
  output logic tm_settled,
  // Readings.
  input wire logic [23:0] meas_value,
  output logic rd_new,
  output logic [23:0] rd_value
);
  logic [7:0] meas_cnt_ff;
  logic [3:0] trig_cnt_ff;
  //////////////////////////////////////////////////////////////////////////
  // Image bytes sum to zero; rom_bad spoils one byte.
  always @(posedge ref_clk)
    rom_data <= ((rom_addr == 8'hFF) ? 8'h7F : rom_addr) ^
      {7'h00, rom_bad && rom_addr == 8'h03};
  // Idle drops with the start pulse and stays low while measuring.
  assign tm_idle = (meas_cnt_ff == 8'h00) && !tm_start;
  always @(posedge ref_clk)
  begin
    if (!rst_n || tm_abort)
      meas_cnt_ff <= 8'h00;
    else if (tm_start || tm_restart)
      meas_cnt_ff <= MEAS_CYC;
    else if (meas_cnt_ff != 8'h00)
      meas_cnt_ff <= meas_cnt_ff - 8'h01;
  end
  // The reading lands just before idle returns.
  always @(posedge ref_clk)
    rd_new <= rst_n && meas_cnt_ff == 8'h02 && !tm_abort;
  assign rd_value = rd_new ? meas_value : ~meas_value;
  // The trigger pointer settles some cycles after a bus trigger.
  always @(posedge ref_clk)
  begin
    tm_settled <= rst_n && trig_cnt_ff == 4'h1;
    if (!rst_n)
      trig_cnt_ff <= 4'h0;
    else if (tm_bus_trig)
      trig_cnt_ff <= TRIG_CYC;
    else if (trig_cnt_ff != 4'h0)
      trig_cnt_ff <= trig_cnt_ff - 4'h1;
  end
endmodule // mcs_core_model

/* sim/mcs_sequencer_tb.sv */
// Purpose: Self-checking bench for the command sequencer.
// Assumes: 25 MHz ref_clk; pulses are sampled on the falling edge.
// Notes: Random readings come from a fixed seed.
`timescale 1ns/10ps
`include "mcs_defs.vh"
module mcs_sequencer_tb;
  logic ref_clk, rst_n, cmd_valid, cmd_ready_ff, talk_addressed;
  logic [3:0] cmd_code;
  logic [1:0] cmd_arg, func_ff, trig_src_ff, a;
  logic tx_strobe_ff, err_strobe_ff, tm_idle, tm_settled, tm_start_ff;
  logic tm_restart_ff, tm_abort_ff, tm_bus_trig_ff, rd_new, buf_has_data;
  logic buf_store_en_ff, buf_abort_ff, cont_init_ff, cfg_defaults_ff;
  logic rom_bad;
  logic [23:0] tx_data_ff, rd_value, meas_value, val, tx_last, s, t;
  logic [15:0] err_code_ff, sample_count, err_last;
  logic [7:0] rom_addr_ff, rom_data;
  logic [23:0] tx_cnt, start_cnt, abort_cnt, rst_cnt, bus_cnt, set_cnt;
  logic [23:0] rd_cnt, babort_cnt;
  int failures, comparisons, i;
  mcs_sequencer i_dut (.ref_clk, .rst_n, .cmd_valid, .cmd_code, .cmd_arg,
    .cmd_ready_ff, .talk_addressed, .tx_strobe_ff, .tx_data_ff,
    .err_strobe_ff, .err_code_ff, .rom_addr_ff, .rom_data, .tm_idle,
    .tm_settled, .tm_start_ff, .tm_restart_ff, .tm_abort_ff,
    .tm_bus_trig_ff, .rd_new, .rd_value, .sample_count, .buf_has_data,
    .buf_store_en_ff, .buf_abort_ff, .func_ff, .trig_src_ff, .cont_init_ff,
    .cfg_defaults_ff);
  mcs_core_model i_core (.ref_clk, .rst_n, .rom_addr(rom_addr_ff), .rom_bad,
    .rom_data, .tm_start(tm_start_ff), .tm_restart(tm_restart_ff),
    .tm_abort(tm_abort_ff), .tm_bus_trig(tm_bus_trig_ff), .tm_idle,
    .tm_settled, .meas_value, .rd_new, .rd_value);
  //////////////////////////////////////////////////////////////////////////
  // Clock and watchdog.
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures = failures + 1;
    end_of_test;
  end
  // Count output pulses where they are settled.
  always @(negedge ref_clk)
  begin
    if (tx_strobe_ff === 1'b1)
      tx_last = tx_data_ff;
    if (err_strobe_ff === 1'b1)
      err_last = err_code_ff;
    tx_cnt = tx_cnt + (tx_strobe_ff === 1'b1);
    start_cnt = start_cnt + (tm_start_ff === 1'b1);
    abort_cnt = abort_cnt + (tm_abort_ff === 1'b1);
    rst_cnt = rst_cnt + (tm_restart_ff === 1'b1);
    bus_cnt = bus_cnt + (tm_bus_trig_ff === 1'b1);
    set_cnt = set_cnt + (tm_settled === 1'b1);
    rd_cnt = rd_cnt + (rd_new === 1'b1);
    babort_cnt = babort_cnt + (buf_abort_ff === 1'b1);
  end
  //////////////////////////////////////////////////////////////////////////
  // Compare and report.
  // Expected self-test code for a good or a spoiled ROM image.
  function [23:0] exp_tst(input bad);
    exp_tst = bad ? `MCS_TST_FAIL : `MCS_TST_PASS;
  endfunction
  // Wide enough that paired values are compared in full.
  task chk(input [47:0] got, input [47:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Offer a command and hold it until cmd_ready_ff reads high after an edge.
  task issue(input [3:0] c, input [1:0] g);
  begin
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= g;
    @(posedge ref_clk);
    for (i = 0; i < 4000 && cmd_ready_ff !== 1'b1; i = i + 1)
      @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  // Wait for the port to free, then let the effects land.
  task wait_ready;
  begin
    for (i = 0; i < 4000 && cmd_ready_ff !== 1'b1; i = i + 1)
      @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  end
  endtask
  task cmd(input [3:0] c, input [1:0] g);
  begin
    issue(c, g);
    wait_ready;
  end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    {rst_n, cmd_valid, cmd_code, cmd_arg, talk_addressed} = '0;
    {buf_has_data, rom_bad, meas_value, failures, comparisons} = '0;
    {tx_cnt, start_cnt, abort_cnt, rst_cnt, bus_cnt, set_cnt} = '0;
    {rd_cnt, babort_cnt, tx_last, err_last} = '0;
    sample_count = 16'h0001;
    void'($urandom(32'hE4E5));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    issue(`MCS_CMD_TST, 2'h0);
    repeat (400) @(posedge ref_clk);
    chk(tx_cnt, 24'h0);
    talk_addressed <= 1'b1;
    wait_ready;
    chk(tx_last, exp_tst(1'b0));
    rom_bad <= 1'b1;
    cmd(`MCS_CMD_TST, 2'h0);
    chk(tx_last, exp_tst(1'b1));
    for (int k = 0; k < 4; k++)
    begin
      a = 2'($urandom % 2);
      val = 24'($urandom);
      meas_value <= val;
      cmd(`MCS_CMD_SRC, `MCS_SRC_BUS);
      cmd(`MCS_CMD_CONT_ON, 2'h0);
      s = babort_cnt;
      cmd(`MCS_CMD_CONF, a);
      chk(func_ff, a);
      chk({cont_init_ff, trig_src_ff}, {1'b0, `MCS_SRC_IMM});
      chk(babort_cnt, s + 1);
      chk({buf_store_en_ff, tm_idle}, 2'h1);
      s = start_cnt;
      cmd(`MCS_CMD_READ, 2'h0);
      chk(tx_last, val);
      chk(start_cnt, s + 1);
      // A changed input, so a fetch that samples it live is caught.
      meas_value <= val ^ 24'h5A5A5A;
      cmd(`MCS_CMD_FETCH, 2'h0);
      chk(tx_last, val);
    end
    cmd(`MCS_CMD_CONT_ON, 2'h0);
    s = start_cnt;
    cmd(`MCS_CMD_INIT, 2'h0);
    chk({err_last, start_cnt}, {`MCS_ERR_INIT_IGN, s});
    s = rst_cnt;
    cmd(`MCS_CMD_ABORT, 2'h0);
    chk(rst_cnt, s + 1);
    cmd(`MCS_CMD_CONT_OFF, 2'h0);
    s = abort_cnt;
    cmd(`MCS_CMD_ABORT, 2'h0);
    chk({abort_cnt, tm_idle}, {s + 24'h1, 1'b1});
    sample_count <= 16'h0003;
    buf_has_data <= 1'b1;
    s = tx_cnt;
    cmd(`MCS_CMD_READ, 2'h0);
    chk({err_last, tx_cnt}, {`MCS_ERR_MEMORY, s});
    sample_count <= 16'h0001;
    cmd(`MCS_CMD_READ, 2'h0);
    chk(tx_cnt, s + 1);
    buf_has_data <= 1'b0;
    s = bus_cnt;
    cmd(`MCS_CMD_TRG, 2'h0);
    chk(bus_cnt, s);
    cmd(`MCS_CMD_SRC, `MCS_SRC_BUS);
    t = set_cnt;
    cmd(`MCS_CMD_TRG, 2'h0);
    cmd(`MCS_CMD_WAI, 2'h0);
    chk({set_cnt, bus_cnt}, {t + 24'h1, s + 24'h1});
    t = rd_cnt;
    cmd(`MCS_CMD_INIT, 2'h0);
    chk(rd_cnt, t);
    cmd(`MCS_CMD_WAI, 2'h0);
    chk({rd_cnt, tm_idle}, {t + 24'h1, 1'b1});
    cmd(`MCS_CMD_CONT_ON, 2'h0);
    val = 24'($urandom);
    meas_value <= val;
    s = abort_cnt;
    cmd(`MCS_CMD_MEAS, `MCS_FUNC_TEMP);
    chk({tx_last, abort_cnt}, {val, s + 24'h2});
    chk({cont_init_ff, func_ff}, {1'b0, `MCS_FUNC_TEMP});
    end_of_test;
  end
endmodule // mcs_sequencer_tb
